/* src/spcf_regs.vh */
// Register map, field positions and codes of the serial port block
`ifndef SPCF_REGS_VH
`define SPCF_REGS_VH
// ==========================================
// Byte addresses
`define SPCF_ADDR_CTRL 8'h00
`define SPCF_ADDR_MODE 8'h04
`define SPCF_ADDR_STAT 8'h08
`define SPCF_ADDR_IEN 8'h0C
`define SPCF_ADDR_ICLR 8'h10
`define SPCF_ADDR_TXD 8'h14
`define SPCF_ADDR_RXD 8'h18
`define SPCF_ADDR_BAUD 8'h1C
// ==========================================
// Command register bits
`define SPCF_CR_RX_ON 4
`define SPCF_CR_RX_OFF 5
`define SPCF_CR_TX_ON 6
`define SPCF_CR_TX_OFF 7
`define SPCF_CR_ERR_CLR 8
// ==========================================
// Mode register fields
`define SPCF_MR_CHAR_LENGTH_FIELD_LSB 6
`define SPCF_MR_SYNC 8
`define SPCF_MR_PAR_LSB 9
`define SPCF_MR_STOP_LSB 12
`define SPCF_MR_CHANNEL_TEST_MODE_FIELD_LSB 14
`define SPCF_MR_BIT_ORDER_SELECT 16
`define SPCF_MR_NINE 17
`define SPCF_MODE_RST 18'h00000
// ==========================================
// Field codes
`define SPCF_PAR_EVEN 3'h0
`define SPCF_PAR_ODD 3'h1
`define SPCF_PAR_SPACE 3'h2
`define SPCF_PAR_MARK 3'h3
`define SPCF_PAR_NONE 3'h4
`define SPCF_PAR_MDROP 3'h6
`define SPCF_STOP_ONE 2'h0
`define SPCF_STOP_ONE_HALF 2'h1
`define SPCF_STOP_TWO 2'h2
`define SPCF_CHM_NORMAL 2'h0
`define SPCF_CHM_ECHO 2'h1
`define SPCF_CHM_LOCAL 2'h2
`define SPCF_CHM_REMOTE 2'h3
// ==========================================
// Event bits of status, enable and clear registers
`define SPCF_EV_RXC 0
`define SPCF_EV_TXC 1
`define SPCF_EV_OVR 2
`define SPCF_EV_UNR 3
`define SPCF_EV_PAR 4
`define SPCF_EV_FRM 5
`define SPCF_EV_W 6
// ==========================================
// Baud divisor and bus answers
`define SPCF_BAUD_RST 16'h06C8
`define SPCF_RESP_OKAY 2'h0
`define SPCF_RESP_SLVERR 2'h2
`endif

/* src/spcf_rx.v */
// Character deserialiser: mid-bit sampling after a low start bit
`timescale 1ns/10ps
module spcf_rx (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire enable,
  input wire line,
  input wire par_en,
  input wire [3:0] nbits,
  input wire bit_order_select,
  input wire [15:0] bit_len,
  output reg [8:0] data_q,
  output reg par_q,
  output reg frame_err_q,
  output reg done_q
);
  localparam S_IDLE = 5'b00001;
  localparam S_START = 5'b00010;
  localparam S_DATA = 5'b00100;
  localparam S_PAR = 5'b01000;
  localparam S_STOP = 5'b10000;
  reg [4:0] st_q;
  reg [15:0] tmr_q;
  reg [3:0] cnt_q;
  reg [8:0] sh_q;
  wire tick = (tmr_q == 16'h0000);
  wire [3:0] idx = bit_order_select ? (nbits - 4'h1 - cnt_q) : cnt_q;
  // Frame sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= S_IDLE;
      tmr_q <= 16'h0000;
      cnt_q <= 4'h0;
      sh_q <= 9'h000;
      data_q <= 9'h000;
      par_q <= 1'b0;
      frame_err_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce) begin
      done_q <= 1'b0;
      if (!tick) tmr_q <= tmr_q - 16'h0001;
      case (st_q)
        S_IDLE: if (enable && !line) begin
          tmr_q <= {1'b0, bit_len[15:1]} - 16'h0001;
          sh_q <= 9'h000;
          st_q <= S_START;
        end
        S_START: if (tick) begin
          cnt_q <= 4'h0;
          tmr_q <= bit_len - 16'h0001;
          st_q <= line ? S_IDLE : S_DATA;
        end
        S_DATA: if (tick) begin
          sh_q[idx] <= line;
          tmr_q <= bit_len - 16'h0001;
          if (cnt_q == nbits - 4'h1) st_q <= par_en ? S_PAR : S_STOP;
          else cnt_q <= cnt_q + 4'h1;
        end
        S_PAR: if (tick) begin
          par_q <= line;
          tmr_q <= bit_len - 16'h0001;
          st_q <= S_STOP;
        end
        default: if (tick) begin
          data_q <= sh_q;
          frame_err_q <= ~line;
          done_q <= 1'b1;
          st_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule

/* src/spcf_top.v */
// Serial port control, character format and AXI4-Lite register file
//
// Notes on behaviour
// - Receiver-on enables receiver unless receiver-off is in the same write.
// - Transmitter-on enables transmitter unless transmitter-off is also set.
// - Error-flag clear command clears overrun and underrun status flags.
// - Length field codes 0 to 3 give 5 to 8 data bits.
// - Nine-bit select forces 9 data bits, else length field rules.
// - Clocking select 0 is asynchronous, 1 is synchronous operation.
// - Parity: even, odd, forced low, forced high, none, multidrop.
// - Stop bits: one, one and half (async only), two.
// - Mode 0 normal; mode 1 echoes receive pin onto transmit pin.
// - Mode 2 feeds transmitter output back into the receiver.
// - Mode 3 ties receive pin to transmit pin internally.
// - Bit order select: 0 least significant first, 1 most first.
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/10ps
`include "spcf_regs.vh"
module spcf_top #(
  parameter [15:0] BAUD_DIV = `SPCF_BAUD_RST
) (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  output reg [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [7:0] s_axi_araddr,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  input wire rxd,
  output wire txd,
  output reg sck_q,
  output wire irq
);

  // ==========================================
  // Parity of a character for the selected type
  function par_of;
    input [2:0] ptype;
    input [8:0] d;
    input addr;
    begin
      case (ptype)
        `SPCF_PAR_EVEN: par_of = ^d;
        `SPCF_PAR_ODD: par_of = ~^d;
        `SPCF_PAR_SPACE: par_of = 1'b0;
        `SPCF_PAR_MARK: par_of = 1'b1;
        default: par_of = addr;
      endcase
    end
  endfunction

  // ==========================================
  // Register state
  reg [17:0] mode_q;
  reg [15:0] baud_q;
  reg [`SPCF_EV_W-1:0] evt_q;
  reg [`SPCF_EV_W-1:0] ien_q;
  reg rx_on_q;
  reg tx_on_q;
  reg [8:0] thr_q;
  reg thr_addr_q;
  reg thr_full_q;
  reg [8:0] rhr_q;
  reg rhr_par_q;
  reg rhr_full_q;
  reg aw_have_q;
  reg w_have_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg [15:0] sck_cnt_q;

  // ==========================================
  // Mode field decode
  wire [1:0] char_length_field = mode_q[`SPCF_MR_CHAR_LENGTH_FIELD_LSB+1:`SPCF_MR_CHAR_LENGTH_FIELD_LSB];
  wire sync_mode = mode_q[`SPCF_MR_SYNC];
  wire [2:0] ptype = mode_q[`SPCF_MR_PAR_LSB+2:`SPCF_MR_PAR_LSB];
  wire [1:0] stop_code = mode_q[`SPCF_MR_STOP_LSB+1:`SPCF_MR_STOP_LSB];
  wire [1:0] channel_test_mode_field = mode_q[`SPCF_MR_CHANNEL_TEST_MODE_FIELD_LSB+1:`SPCF_MR_CHANNEL_TEST_MODE_FIELD_LSB];
  wire bit_order_select = mode_q[`SPCF_MR_BIT_ORDER_SELECT];
  wire nine = mode_q[`SPCF_MR_NINE];
  // Character length in bits
  wire [3:0] nbits = nine ? 4'h9 : 4'h5 + {2'b00, char_length_field};
  wire [8:0] dmask = ~(9'h1FF << nbits);
  // Parity present for real parity types and multidrop
  wire par_en = (ptype[2] == 1'b0) || (ptype == `SPCF_PAR_MDROP);
  // Stop length in half-bit units; 1.5 is reserved when synchronous
  reg [2:0] stop_halves;
  always @* begin
    case (stop_code)
      `SPCF_STOP_ONE_HALF: stop_halves = sync_mode ? 3'h2 : 3'h3;
      `SPCF_STOP_TWO: stop_halves = 3'h4;
      default: stop_halves = 3'h2;
    endcase
  end
  // Bit period, never below two cycles
  wire [15:0] bit_len = (baud_q < 16'h0002) ? 16'h0002 : baud_q;

  // ==========================================
  // Serial engines and channel routing
  wire tx_line;
  wire tx_busy;
  wire tx_done;
  wire rx_in;
  wire [8:0] rx_data;
  wire rx_par;
  wire rx_ferr;
  wire rx_done;
  wire tx_start = tx_on_q && thr_full_q && !tx_busy;
  // Receiver source: pin, or own transmitter in local loopback
  assign rx_in = (channel_test_mode_field == `SPCF_CHM_LOCAL) ? tx_line : rxd;
  // Transmit pin: echo or remote loopback pass the receive pin
  assign txd = (channel_test_mode_field == `SPCF_CHM_ECHO) ? rxd :
               (channel_test_mode_field == `SPCF_CHM_REMOTE) ? rxd :
               (channel_test_mode_field == `SPCF_CHM_LOCAL) ? 1'b1 : tx_line;

  spcf_tx u_tx (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .start(tx_start),
    .data(thr_q & dmask),
    .par_bit(par_of(ptype, thr_q & dmask, thr_addr_q)),
    .par_en(par_en),
    .nbits(nbits),
    .stop_halves(stop_halves),
    .bit_order_select(bit_order_select),
    .bit_len(bit_len),
    .line(tx_line),
    .busy(tx_busy),
    .done_q(tx_done)
  );

  spcf_rx u_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .enable(rx_on_q),
    .line(rx_in),
    .par_en(par_en),
    .nbits(nbits),
    .bit_order_select(bit_order_select),
    .bit_len(bit_len),
    .data_q(rx_data),
    .par_q(rx_par),
    .frame_err_q(rx_ferr),
    .done_q(rx_done)
  );

  // ==========================================
  // AXI4-Lite handshakes
  assign s_axi_awready = ce && !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = ce && !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = ce && !s_axi_rvalid;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire wr_go = aw_have_q && w_have_q;
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [31:0] wd = wdata_q & wmask;
  // Decoded write strobes
  wire wr_ctrl = wr_go && (awaddr_q == `SPCF_ADDR_CTRL);
  wire wr_mode = wr_go && (awaddr_q == `SPCF_ADDR_MODE);
  wire wr_ien = wr_go && (awaddr_q == `SPCF_ADDR_IEN);
  wire wr_iclr = wr_go && (awaddr_q == `SPCF_ADDR_ICLR);
  wire wr_txd = wr_go && (awaddr_q == `SPCF_ADDR_TXD);
  wire wr_baud = wr_go && (awaddr_q == `SPCF_ADDR_BAUD);
  wire wr_ok = wr_ctrl || wr_mode || wr_ien || wr_iclr || wr_txd || wr_baud ||
               (awaddr_q == `SPCF_ADDR_STAT) || (awaddr_q == `SPCF_ADDR_RXD);
  wire rd_rxd = ar_take && (s_axi_araddr[7:2] == `SPCF_ADDR_RXD >> 2);

  // Address and data capture, in either order, and write answer
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SPCF_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `SPCF_RESP_OKAY : `SPCF_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data multiplexer
  reg [31:0] rd_mux;
  reg rd_ok;
  always @* begin
    rd_mux = 32'h00000000;
    rd_ok = 1'b1;
    if (s_axi_araddr[7:2] == `SPCF_ADDR_MODE >> 2) begin
      rd_mux = {14'h0000, mode_q};
    end else if (s_axi_araddr[7:2] == `SPCF_ADDR_STAT >> 2) begin
      rd_mux = {20'h00000, tx_on_q, rx_on_q, !thr_full_q, rhr_full_q, 2'b00, evt_q};
    end else if (s_axi_araddr[7:2] == `SPCF_ADDR_IEN >> 2) begin
      rd_mux = {26'h0000000, ien_q};
    end else if (s_axi_araddr[7:2] == `SPCF_ADDR_RXD >> 2) begin
      rd_mux = {16'h0000, rhr_par_q, 6'h00, rhr_q};
    end else if (s_axi_araddr[7:2] == `SPCF_ADDR_BAUD >> 2) begin
      rd_mux = {16'h0000, baud_q};
    end else if (s_axi_araddr[7:2] == `SPCF_ADDR_CTRL >> 2) begin
      rd_mux = 32'h00000000;
    end else if (s_axi_araddr[7:2] == `SPCF_ADDR_ICLR >> 2) begin
      rd_mux = 32'h00000000;
    end else if (s_axi_araddr[7:2] == `SPCF_ADDR_TXD >> 2) begin
      rd_mux = 32'h00000000;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Read answer, one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SPCF_RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? `SPCF_RESP_OKAY : `SPCF_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================
  // Configuration registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= `SPCF_MODE_RST;
      baud_q <= BAUD_DIV;
      ien_q <= {`SPCF_EV_W{1'b0}};
    end else if (ce) begin
      if (wr_mode) mode_q <= (mode_q & ~wmask[17:0]) | wd[17:0];
      if (wr_baud) baud_q <= (baud_q & ~wmask[15:0]) | wd[15:0];
      if (wr_ien) ien_q <= (ien_q & ~wmask[`SPCF_EV_W-1:0]) | wd[`SPCF_EV_W-1:0];
    end
  end

  // Enable commands; the off bit wins over the on bit
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_on_q <= 1'b0;
      tx_on_q <= 1'b0;
    end else if (ce && wr_ctrl) begin
      if (wd[`SPCF_CR_RX_OFF]) rx_on_q <= 1'b0;
      else if (wd[`SPCF_CR_RX_ON]) rx_on_q <= 1'b1;
      if (wd[`SPCF_CR_TX_OFF]) tx_on_q <= 1'b0;
      else if (wd[`SPCF_CR_TX_ON]) tx_on_q <= 1'b1;
    end
  end

  // ==========================================
  // Holding registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      thr_q <= 9'h000;
      thr_addr_q <= 1'b0;
      thr_full_q <= 1'b0;
      rhr_q <= 9'h000;
      rhr_par_q <= 1'b0;
      rhr_full_q <= 1'b0;
    end else if (ce) begin
      if (wr_txd && !thr_full_q) begin
        thr_q <= wd[8:0];
        thr_addr_q <= wd[15];
        thr_full_q <= 1'b1;
      end else if (tx_start) begin
        thr_full_q <= 1'b0;
      end
      // Arrival wins over a read in the same cycle
      if (rx_done) begin
        rhr_q <= rx_data;
        rhr_par_q <= rx_par;
        rhr_full_q <= 1'b1;
      end else if (rd_rxd) begin
        rhr_full_q <= 1'b0;
      end
    end
  end

  // ==========================================
  // Sticky events: set wins over any clear
  wire par_bad = par_en && (ptype != `SPCF_PAR_MDROP) && (rx_par != par_of(ptype, rx_data, 1'b0));
  reg [`SPCF_EV_W-1:0] ev_set;
  reg [`SPCF_EV_W-1:0] ev_clr;
  always @* begin
    ev_set = {`SPCF_EV_W{1'b0}};
    ev_set[`SPCF_EV_RXC] = rx_done;
    ev_set[`SPCF_EV_TXC] = tx_done;
    ev_set[`SPCF_EV_OVR] = rx_done && rhr_full_q && !rd_rxd;
    ev_set[`SPCF_EV_UNR] = tx_done && sync_mode && tx_on_q && !thr_full_q;
    ev_set[`SPCF_EV_PAR] = rx_done && par_bad;
    ev_set[`SPCF_EV_FRM] = rx_done && rx_ferr;
    ev_clr = wr_iclr ? wd[`SPCF_EV_W-1:0] : {`SPCF_EV_W{1'b0}};
    if (wr_ctrl && wd[`SPCF_CR_ERR_CLR]) begin
      ev_clr[`SPCF_EV_OVR] = 1'b1;
      ev_clr[`SPCF_EV_UNR] = 1'b1;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      evt_q <= {`SPCF_EV_W{1'b0}};
    end else if (ce) begin
      evt_q <= (evt_q & ~ev_clr) | ev_set;
    end
  end

  // Level interrupt from enabled sticky bits
  assign irq = |(evt_q & ien_q);

  // ==========================================
  // Synchronous bit clock: toggles each half bit
  always @(posedge aclk) begin
    if (!aresetn) begin
      sck_cnt_q <= 16'h0000;
      sck_q <= 1'b0;
    end else if (ce) begin
      if (!sync_mode) begin
        sck_cnt_q <= 16'h0000;
        sck_q <= 1'b0;
      end else if (sck_cnt_q == {1'b0, bit_len[15:1]} - 16'h0001) begin
        sck_cnt_q <= 16'h0000;
        sck_q <= ~sck_q;
      end else begin
        sck_cnt_q <= sck_cnt_q + 16'h0001;
      end
    end
  end

endmodule

/* src/spcf_tx.v */
// Character serialiser: start, data, optional parity, stop half-bits
`timescale 1ns/10ps
module spcf_tx (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire start,
  input wire [8:0] data,
  input wire par_bit,
  input wire par_en,
  input wire [3:0] nbits,
  input wire [2:0] stop_halves,
  input wire bit_order_select,
  input wire [15:0] bit_len,
  output wire line,
  output wire busy,
  output reg done_q
);
  localparam S_IDLE = 5'b00001;
  localparam S_START = 5'b00010;
  localparam S_DATA = 5'b00100;
  localparam S_PAR = 5'b01000;
  localparam S_STOP = 5'b10000;
  reg [4:0] st_q;
  reg [15:0] tmr_q;
  reg [3:0] cnt_q;
  reg [8:0] sh_q;
  reg par_q;
  wire tick = (tmr_q == 16'h0000);
  wire [3:0] idx = bit_order_select ? (nbits - 4'h1 - cnt_q) : cnt_q;
  // Line level from state; idles high
  assign line = st_q[1] ? 1'b0 : st_q[2] ? sh_q[idx] : st_q[3] ? par_q : 1'b1;
  assign busy = ~st_q[0];
  // Frame sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= S_IDLE;
      tmr_q <= 16'h0000;
      cnt_q <= 4'h0;
      sh_q <= 9'h000;
      par_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce) begin
      done_q <= 1'b0;
      if (!tick) tmr_q <= tmr_q - 16'h0001;
      case (st_q)
        S_IDLE: if (start) begin
          sh_q <= data;
          par_q <= par_bit;
          tmr_q <= bit_len - 16'h0001;
          st_q <= S_START;
        end
        S_START: if (tick) begin
          cnt_q <= 4'h0;
          tmr_q <= bit_len - 16'h0001;
          st_q <= S_DATA;
        end
        S_DATA: if (tick) begin
          if (cnt_q == nbits - 4'h1) begin
            cnt_q <= 4'h0;
            st_q <= par_en ? S_PAR : S_STOP;
            tmr_q <= par_en ? bit_len - 16'h0001 : {1'b0, bit_len[15:1]} - 16'h0001;
          end else begin
            cnt_q <= cnt_q + 4'h1;
            tmr_q <= bit_len - 16'h0001;
          end
        end
        S_PAR: if (tick) begin
          st_q <= S_STOP;
          tmr_q <= {1'b0, bit_len[15:1]} - 16'h0001;
        end
        default: if (tick) begin
          tmr_q <= {1'b0, bit_len[15:1]} - 16'h0001;
          if (cnt_q == {1'b0, stop_halves} - 4'h1) begin
            st_q <= S_IDLE;
            done_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
      endcase
    end
  end
endmodule

/* test/spcf_remote.sv */
// Remote serial device model on the transmit and receive pins
`timescale 1ns/10ps
module spcf_remote #(
  parameter int BL = 8
) (
  input wire logic aclk,
  input wire logic txd,
  output logic rxd
);
  // Line idles high
  initial rxd = 1'h1;
  // Drives one frame, first element first, then idles one cycle
  task automatic send(input logic [12:0] f, input int n);
    for (int k = 0; k < n; k++) begin
      rxd <= f[k];
      repeat (BL) @(posedge aclk);
    end
    rxd <= 1'h1;
    @(posedge aclk);
  endtask
  // Waits for the start edge, then samples each bit at its middle
  task automatic recv(input int n, output logic [12:0] f);
    f = 13'h1FFF;
    do @(posedge aclk); while (txd !== 1'h0);
    repeat (BL / 2 - 1) @(posedge aclk);
    for (int k = 0; k < n; k++) begin
      f[k] = txd;
      repeat (BL) @(posedge aclk);
    end
  endtask
endmodule

/* test/spcf_top_sva.sv */
// Concurrent checks on the bus handshakes and serial line of the serial port
`timescale 1ns/10ps
module spcf_top_sva (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire txd,
  input wire sck_q,
  input wire irq
);
  // ==========================================
  // Clocking and reset
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========================================
  // Bus transfers
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Answers follow the taken request
  AST_B_ANSWER: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  AST_R_ANSWER: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data missing");
  // Answers stand until accepted; the write answer then drops
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  // No new request taken while an answer is pending
  AST_B_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  // ==========================================
  // Serial line
  AST_START_BIT: assert property ($fell(txd) |=> !txd)
    else $error("start bit too short");
  AST_RESET_IDLE: assert property ($rose(aresetn) |-> txd && !sck_q && !irq)
    else $error("line not idle after reset");
endmodule

/* test/tb_top.sv */
// Self-checking bench for the serial port control block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  localparam int BL = 8;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic ce = 1'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rxd, txd, sck_q, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int failures = 0, compares = 0, cyc = 0;
  int t_n [6] = '{5, 6, 7, 8, 8, 9};
  int t_s [6] = '{1, 2, 1, 1, 2, 1};
  logic [2:0] t_p [6] = '{3'h4, 3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
  logic t_m [6] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
  logic [8:0] t_d [6] = '{9'h015, 9'h02D, 9'h04B, 9'h0A5, 9'h03C, 9'h1A5};
  logic [1:0] t_c [5] = '{2'h3, 2'h1, 2'h0, 2'h2, 2'h1};
  logic t_e [5] = '{1'h0, 1'h1, 1'h1, 1'h0, 1'h1};
  // ==========================================
  // Design and remote device
  spcf_top #(.BAUD_DIV(16'h0008)) i_dut (.aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .rxd, .txd, .sck_q, .irq);
  spcf_remote #(.BL(BL)) i_rem (.aclk, .txd, .rxd);
  // Clock and hang limit
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end
  // ==========================================
  // Verdict
  task automatic final_report();
    if (failures == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Bus write with response code
  task automatic wrr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ah, wh;
    ah = 1'h0;
    wh = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(ah && wh)) begin
      @(posedge aclk);
      if (!ah && s_axi_awready) begin
        ah = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!wh && s_axi_wready) begin
        wh = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    repeat (2) @(posedge aclk);
    s_axi_bready <= 1'h1;
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wrr(a, d, r);
    `CHK("bresp", 2'h0, r)
  endtask
  // Bus read with response code
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    @(posedge aclk);
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    rdr(a, d, r);
    `CHK("rresp", 2'h0, r)
  endtask
  // Counts low line cycles and clock toggles
  task automatic watch(input int n, output int lows, output int tog);
    logic s;
    lows = 0;
    tog = 0;
    s = sck_q;
    repeat (n) begin
      @(posedge aclk);
      lows += (txd === 1'h0);
      tog += (sck_q !== s);
      s = sck_q;
    end
  endtask
  // Expected wire sequence: start, data, parity, stops
  function automatic logic [12:0] frame(input logic [8:0] dt, input int n, input logic msb, input logic [2:0] p,
      input int s, output int len);
    logic [12:0] f;
    logic [8:0] x;
    x = dt & ~(9'h1FF << n);
    f = 13'h1FFE;
    for (int k = 0; k < n; k++) f[k + 1] = msb ? x[n - 1 - k] : x[k];
    len = 1 + n + s + (p != 3'h4);
    if (p != 3'h4) f[n + 1] = (p == 3'h0) ? ^x : (p == 3'h1) ? ~^x : (p == 3'h3);
    return f;
  endfunction
  // ==========================================
  // Main sequence
  initial begin
    logic [31:0] d, m;
    logic [1:0] r;
    logic [12:0] f, g;
    int len, lows, tog, n;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(8'h04, d);
    `CHK("mode reset", 32'h0, d)
    rd(8'h1C, d);
    `CHK("baud reset", 32'h8, d)
    rd(8'h08, d);
    `CHK("status reset", 8'h0, {d[11:10], d[5:0]})
    rdr(8'h20, d, r);
    `CHK("unmapped read", 2'h2, r)
    wrr(8'h24, 32'h1, r);
    `CHK("unmapped write", 2'h2, r)
    // Enable and disable commands for both directions
    for (int i = 0; i < 5; i++) begin
      wr(8'h00, {24'h0, t_c[i], t_c[i], 4'h0});
      rd(8'h08, d);
      `CHK("rx tx enabled", {t_e[i], t_e[i]}, d[11:10])
    end
    // Character formats on the transmit and receive pins
    for (int i = 0; i < 6; i++) begin
      n = t_n[i];
      m = {14'h0, n == 9, t_m[i], 2'h0, (t_s[i] == 2) ? 2'h2 : 2'h0, t_p[i], 1'h0, (n == 9) ? 2'h0 : 2'(n - 5), 6'h0};
      f = frame(t_d[i], n, t_m[i], t_p[i], t_s[i], len);
      wr(8'h04, m);
      fork
        wr(8'h14, {23'h0, t_d[i]});
        i_rem.recv(len, g);
      join
      `CHK("tx frame", f & ~(13'h1FFF << len), g & ~(13'h1FFF << len))
      i_rem.send(f, len);
      rd(8'h18, d);
      `CHK("rx data", t_d[i] & ~(9'h1FF << n), d[8:0])
      if (t_p[i] != 3'h4) `CHK("rx parity bit", f[n + 1], d[15])
      rd(8'h08, d);
      `CHK("rx errors", 2'h0, d[5:4])
    end
    // Overrun, masked interrupt and error clear
    wr(8'h0C, 32'h4);
    `CHK("irq masked", 1'h0, irq)
    i_rem.send(f, len);
    i_rem.send(f, len);
    `CHK("overrun irq", 1'h1, irq)
    rd(8'h08, d);
    `CHK("overrun flag", 1'h1, d[2])
    wr(8'h00, 32'h100);
    rd(8'h08, d);
    `CHK("overrun cleared", 1'h0, d[2])
    `CHK("irq dropped", 1'h0, irq)
    wr(8'h10, 32'h3F);
    rd(8'h18, d);
    rd(8'h08, d);
    `CHK("events cleared", 6'h0, d[5:0])
    // Echo, local loopback and remote loopback
    f = frame(9'h05A, 8, 1'h0, 3'h4, 1, len);
    for (int i = 1; i < 4; i++) begin
      wr(8'h04, 32'h8C0 | (i << 14));
      if (i == 2) begin
        fork
          wr(8'h14, 32'h5A);
          watch(14 * BL, lows, tog);
        join
        `CHK("txd held high", 0, lows)
      end else begin
        fork
          i_rem.send(f, len);
          i_rem.recv(len, g);
        join
        `CHK("txd mirrors rxd", f & 13'h3FF, g & 13'h3FF)
      end
      rd(8'h18, d);
      `CHK("receiver data", 9'h05A, d[8:0])
    end
    // Synchronous operation and underrun
    wr(8'h04, 32'h9C0);
    fork
      wr(8'h14, 32'h5A);
      i_rem.recv(len, g);
    join
    `CHK("sync frame", f & 13'h3FF, g & 13'h3FF)
    watch(2 * BL, lows, tog);
    `CHK("sck running", 1'h1, tog > 0)
    rd(8'h08, d);
    `CHK("underrun flag", 1'h1, d[3])
    wr(8'h00, 32'h100);
    rd(8'h08, d);
    `CHK("underrun cleared", 1'h0, d[3])
    wr(8'h04, 32'h8C0);
    watch(2 * BL, lows, tog);
    `CHK("sck idle", 0, tog)
    `CHK("sck low", 1'h0, sck_q)
    final_report();
  end
endmodule
bind spcf_top spcf_top_sva i_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .txd, .sck_q, .irq);
